/* aiw_pkg.sv */
/*
 * Package for the accelerometer interrupt and wake controller: register
 * offsets, field positions, reset values and oversampling scheme codes.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
`default_nettype none
package aiw_pkg;
    localparam logic [7:0] ADDR_INT_SOURCE = 8'h0C;
    localparam logic [7:0] ADDR_WAKE_CFG = 8'h2C;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h2D;
    localparam logic [7:0] ADDR_INT_ROUTE = 8'h2E;
    // Wake and pin configuration fields.
    localparam int WAKE_TRANS_BIT = 6;
    localparam int WAKE_ORIENT_BIT = 5;
    localparam int WAKE_PULSE_BIT = 4;
    localparam int WAKE_FFMT_BIT = 3;
    localparam int POLARITY_BIT = 1;
    localparam int DRIVE_BIT = 0;
    localparam logic [7:0] WAKE_CFG_MASK = 8'h7B;
    // Source positions shared by enable, routing and source registers.
    localparam int SRC_ASLP_BIT = 7;
    localparam int SRC_TRANS_BIT = 5;
    localparam int SRC_ORIENT_BIT = 4;
    localparam int SRC_PULSE_BIT = 3;
    localparam int SRC_FFMT_BIT = 2;
    localparam int SRC_DRDY_BIT = 0;
    localparam logic [7:0] SRC_MASK = 8'hBD;
    localparam logic [7:0] WAKE_SRC_MASK = 8'h3C;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Oversampling power scheme codes.
    typedef enum logic [1:0] {
        OS_NORMAL = 2'h0,
        OS_LOW_NOISE_LOW_POWER = 2'h1,
        OS_HIGH_RESOLUTION = 2'h2,
        OS_LOW_POWER = 2'h3
    } aiw_os_scheme_t;
endpackage : aiw_pkg
`default_nettype wire

/* aiw_reg_file.sv */
/*
 * Three-register store for the interrupt and wake controller. Read data
 * come out of a register one cycle after the read strobe.
 * Assumes write and read strobes are single-cycle and synchronous to clk.
 */
`default_nettype none
module aiw_reg_file (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous active-high reset.
    input wire logic wrEn, // Write strobe.
    input wire logic rdEn, // Read strobe.
    input wire logic [7:0] addr, // Register address.
    input wire logic [7:0] wrData, // Write data.
    input wire logic [7:0] srcStatus, // Interrupt source status for reads.
    output logic [7:0] rdData, // Registered read data.
    output logic [7:0] wakeCfg, // Wake and pin configuration.
    output logic [7:0] intEnable, // Interrupt enables.
    output logic [7:0] intRoute // Pin routing.
);
    logic [7:0] wakeCfg_q, wakeCfg_d;
    logic [7:0] intEnable_q, intEnable_d;
    logic [7:0] intRoute_q, intRoute_d;
    logic [7:0] rdData_q, rdData_d;

    // Next-state of the store; unused bits are masked so they stay zero.
    always_comb begin
        wakeCfg_d = wakeCfg_q;
        intEnable_d = intEnable_q;
        intRoute_d = intRoute_q;
        rdData_d = rdData_q;
        if (wrEn) begin
            case (addr)
                aiw_pkg::ADDR_WAKE_CFG: wakeCfg_d = wrData & aiw_pkg::WAKE_CFG_MASK;
                aiw_pkg::ADDR_INT_ENABLE: intEnable_d = wrData & aiw_pkg::SRC_MASK;
                aiw_pkg::ADDR_INT_ROUTE: intRoute_d = wrData & aiw_pkg::SRC_MASK;
                default: ;
            endcase
        end
        if (rdEn) begin
            case (addr)
                aiw_pkg::ADDR_INT_SOURCE: rdData_d = srcStatus;
                aiw_pkg::ADDR_WAKE_CFG: rdData_d = wakeCfg_q;
                aiw_pkg::ADDR_INT_ENABLE: rdData_d = intEnable_q;
                aiw_pkg::ADDR_INT_ROUTE: rdData_d = intRoute_q;
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // All fields take their default of zero at reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            wakeCfg_q <= aiw_pkg::RESET_VALUE;
            intEnable_q <= aiw_pkg::RESET_VALUE;
            intRoute_q <= aiw_pkg::RESET_VALUE;
            rdData_q <= 8'h00;
        end else begin
            wakeCfg_q <= wakeCfg_d;
            intEnable_q <= intEnable_d;
            intRoute_q <= intRoute_d;
            rdData_q <= rdData_d;
        end
    end

    assign wakeCfg = wakeCfg_q;
    assign intEnable = intEnable_q;
    assign intRoute = intRoute_q;
    assign rdData = rdData_q;
endmodule : aiw_reg_file
`default_nettype wire

/* aiw_irq_wake_ctrl.sv */
/*
 * Interrupt and wake controller of the accelerometer: gates detector event
 * flags by enable, routes them to two interrupt pins with selectable
 * polarity and drive type, builds the wake request, and decodes the
 * active and sleep oversampling schemes.
 * Assumes detector flags are synchronous levels held until the host reads
 * and clears them in the detectors, and an 8-bit register port.
 */
// Notes on behaviour
// - Each two-bit oversampling field decodes 00 normal, 01 LNLP, 10 high-res, 11 low power.
// - Transient wakes the device from sleep only when wake bit 6 is set.
// - Orientation wakes the device from sleep only when wake bit 5 is set.
// - Pulse detection wakes the device from sleep only when wake bit 4 is set.
// - Freefall/motion wakes the device from sleep only when wake bit 3 is set.
// - Polarity bit 1 selects active-low pins at 0, active-high at 1.
// - Drive bit 0 selects push-pull at 0, open drain at 1.
// - A flag reaches routing only while its enable bit is set; enables reset 0.
// - Enable bits: auto-sleep 7, transient 5, orientation 4, pulse 3, freefall 2, ready 0.
// - Routing bit 0 sends a source to the second pin, 1 to the first.
// - Routing register uses the same bit positions as the enable register.
// - A pin asserts whenever any enabled source routed to it is active.
// - Wake needs both the enable bit and the wake bit set.
// - Auto-sleep and data-ready events never wake or restart the sleep timer.
`default_nettype none
module aiw_irq_wake_ctrl (
    input wire logic clk, // System clock, 10 MHz.
    input wire logic rst, // Synchronous active-high reset.
    input wire logic regWrEn, // Register write strobe.
    input wire logic regRdEn, // Register read strobe.
    input wire logic [7:0] regAddr, // Register address.
    input wire logic [7:0] regWrData, // Register write data.
    output logic [7:0] regRdData, // Registered read data.
    input wire logic srcAutosleep, // Auto-sleep/wake event flag.
    input wire logic srcTransient, // Transient event flag.
    input wire logic srcOrientation, // Orientation event flag.
    input wire logic srcPulse, // Pulse event flag.
    input wire logic srcFreefallMotion, // Freefall/motion event flag.
    input wire logic srcDataReady, // Data-ready event flag.
    input wire logic [1:0] activeOversampleScheme, // Active-phase scheme field.
    input wire logic [1:0] sleepOversampleScheme, // Sleep-phase scheme field.
    input wire logic sleeping, // Device is in its sleep phase.
    output aiw_pkg::aiw_os_scheme_t currentScheme, // Scheme in force now.
    output logic wakeRequest, // Wake from sleep and restart sleep timer.
    output logic irqPinFirstOut, // First pin output level.
    output logic irqPinFirstOe, // First pin output enable.
    output logic irqPinSecondOut, // Second pin output level.
    output logic irqPinSecondOe // Second pin output enable.
);
    logic [7:0] wakeCfg, intEnable, intRoute, srcVec, enabledSrc;
    logic firstActive, secondActive;
    logic wakeRequest_d, wakeRequest_q;
    logic firstOut_d, firstOut_q, firstOe_d, firstOe_q;
    logic secondOut_d, secondOut_q, secondOe_d, secondOe_q;
    aiw_pkg::aiw_os_scheme_t scheme_d, scheme_q;

    // Maps a raw two-bit field onto the scheme enumeration.
    function automatic aiw_pkg::aiw_os_scheme_t decodeScheme(input logic [1:0] f);
        case (f)
            2'h0: decodeScheme = aiw_pkg::OS_NORMAL;
            2'h1: decodeScheme = aiw_pkg::OS_LOW_NOISE_LOW_POWER;
            2'h2: decodeScheme = aiw_pkg::OS_HIGH_RESOLUTION;
            default: decodeScheme = aiw_pkg::OS_LOW_POWER;
        endcase
    endfunction : decodeScheme

    // Pin level for an asserted or idle interrupt under the polarity bit.
    function automatic logic pinLevel(input logic active, input logic pol);
        pinLevel = pol ? active : ~active;
    endfunction : pinLevel

    // Source vector laid out in register bit order.
    always_comb begin
        srcVec = 8'h00;
        srcVec[aiw_pkg::SRC_ASLP_BIT] = srcAutosleep;
        srcVec[aiw_pkg::SRC_TRANS_BIT] = srcTransient;
        srcVec[aiw_pkg::SRC_ORIENT_BIT] = srcOrientation;
        srcVec[aiw_pkg::SRC_PULSE_BIT] = srcPulse;
        srcVec[aiw_pkg::SRC_FFMT_BIT] = srcFreefallMotion;
        srcVec[aiw_pkg::SRC_DRDY_BIT] = srcDataReady;
    end

    aiw_reg_file u_regs (
        .clk(clk),
        .rst(rst),
        .wrEn(regWrEn),
        .rdEn(regRdEn),
        .addr(regAddr),
        .wrData(regWrData),
        .srcStatus(srcVec),
        .rdData(regRdData),
        .wakeCfg(wakeCfg),
        .intEnable(intEnable),
        .intRoute(intRoute)
    );

    // Enable gating and per-pin collection; routing shares enable positions.
    assign enabledSrc = srcVec & intEnable;
    assign firstActive = |(enabledSrc & intRoute);
    assign secondActive = |(enabledSrc & ~intRoute);

    // Next pin state. Open drain only ever pulls to the asserted level and
    // releases otherwise; push-pull drives both levels all the time.
    always_comb begin
        firstOut_d = pinLevel(firstActive, wakeCfg[aiw_pkg::POLARITY_BIT]);
        secondOut_d = pinLevel(secondActive, wakeCfg[aiw_pkg::POLARITY_BIT]);
        firstOe_d = ~wakeCfg[aiw_pkg::DRIVE_BIT] | firstActive;
        secondOe_d = ~wakeCfg[aiw_pkg::DRIVE_BIT] | secondActive;
        // Wake bits sit one place above their sources, so shift down to align.
        wakeRequest_d = sleeping
                        & |(enabledSrc & aiw_pkg::WAKE_SRC_MASK
                            & {1'b0, wakeCfg[7:1]});
        scheme_d = sleeping ? decodeScheme(sleepOversampleScheme)
                            : decodeScheme(activeOversampleScheme);
    end

    // Outputs are registered so the pads never see decode glitches.
    always_ff @(posedge clk) begin
        if (rst) begin
            firstOut_q <= 1'b1;
            secondOut_q <= 1'b1;
            firstOe_q <= 1'b1;
            secondOe_q <= 1'b1;
            wakeRequest_q <= 1'b0;
            scheme_q <= aiw_pkg::OS_NORMAL;
        end else begin
            firstOut_q <= firstOut_d;
            secondOut_q <= secondOut_d;
            firstOe_q <= firstOe_d;
            secondOe_q <= secondOe_d;
            wakeRequest_q <= wakeRequest_d;
            scheme_q <= scheme_d;
        end
    end

    assign irqPinFirstOut = firstOut_q;
    assign irqPinFirstOe = firstOe_q;
    assign irqPinSecondOut = secondOut_q;
    assign irqPinSecondOe = secondOe_q;
    assign wakeRequest = wakeRequest_q;
    assign currentScheme = scheme_q;

    property p_transient_wake;
        @(posedge clk) disable iff (rst)
        (sleeping && srcTransient && intEnable[aiw_pkg::SRC_TRANS_BIT]
         && wakeCfg[aiw_pkg::WAKE_TRANS_BIT]) |=> wakeRequest;
    endproperty
    a_transient_wake: assert property (p_transient_wake)
        else $error("transient did not wake");

    property p_orient_wake;
        @(posedge clk) disable iff (rst)
        (sleeping && srcOrientation && intEnable[aiw_pkg::SRC_ORIENT_BIT]
         && wakeCfg[aiw_pkg::WAKE_ORIENT_BIT]) |=> wakeRequest;
    endproperty
    a_orient_wake: assert property (p_orient_wake)
        else $error("orientation did not wake");

    property p_pulse_wake;
        @(posedge clk) disable iff (rst)
        (sleeping && srcPulse && intEnable[aiw_pkg::SRC_PULSE_BIT]
         && wakeCfg[aiw_pkg::WAKE_PULSE_BIT]) |=> wakeRequest;
    endproperty
    a_pulse_wake: assert property (p_pulse_wake)
        else $error("pulse did not wake");

    property p_ffmt_wake;
        @(posedge clk) disable iff (rst)
        (sleeping && srcFreefallMotion && intEnable[aiw_pkg::SRC_FFMT_BIT]
         && wakeCfg[aiw_pkg::WAKE_FFMT_BIT]) |=> wakeRequest;
    endproperty
    a_ffmt_wake: assert property (p_ffmt_wake)
        else $error("freefall did not wake");

    property p_no_wake_others;
        @(posedge clk) disable iff (rst)
        !(|(enabledSrc & aiw_pkg::WAKE_SRC_MASK & {1'b0, wakeCfg[7:1]})) |=> !wakeRequest;
    endproperty
    a_no_wake_others: assert property (p_no_wake_others)
        else $error("spurious wake");

    property p_first_level;
        @(posedge clk) disable iff (rst)
        1'b1 |=> irqPinFirstOut == ($past(wakeCfg[aiw_pkg::POLARITY_BIT]) ~^ $past(firstActive));
    endproperty
    a_first_level: assert property (p_first_level)
        else $error("first pin level wrong");

    property p_second_route;
        @(posedge clk) disable iff (rst)
        (srcDataReady && intEnable[aiw_pkg::SRC_DRDY_BIT] && !intRoute[aiw_pkg::SRC_DRDY_BIT]
         && wakeCfg[aiw_pkg::POLARITY_BIT]) |=> irqPinSecondOut;
    endproperty
    a_second_route: assert property (p_second_route)
        else $error("second pin not routed");

    property p_first_route;
        @(posedge clk) disable iff (rst)
        (srcPulse && intEnable[aiw_pkg::SRC_PULSE_BIT] && intRoute[aiw_pkg::SRC_PULSE_BIT]
         && !wakeCfg[aiw_pkg::POLARITY_BIT]) |=> !irqPinFirstOut;
    endproperty
    a_first_route: assert property (p_first_route)
        else $error("first pin not routed");

    property p_disabled_quiet;
        @(posedge clk) disable iff (rst)
        (intEnable == 8'h00 && !wakeCfg[aiw_pkg::DRIVE_BIT]) |=> (irqPinFirstOe && irqPinSecondOe
            && irqPinFirstOut == !$past(wakeCfg[aiw_pkg::POLARITY_BIT]));
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled source leaked");

    property p_open_drain_release;
        @(posedge clk) disable iff (rst)
        (wakeCfg[aiw_pkg::DRIVE_BIT] && !firstActive) |=> !irqPinFirstOe;
    endproperty
    a_open_drain_release: assert property (p_open_drain_release)
        else $error("open drain drove idle");

    property p_scheme;
        @(posedge clk) disable iff (rst)
        !sleeping |=> currentScheme == aiw_pkg::aiw_os_scheme_t'($past(activeOversampleScheme));
    endproperty
    a_scheme: assert property (p_scheme)
        else $error("active scheme wrong");

    c_first_pin: cover property (@(posedge clk) disable iff (rst) firstActive);
    c_both_pins: cover property (@(posedge clk) disable iff (rst) firstActive && secondActive);
    c_wake: cover property (@(posedge clk) disable iff (rst) wakeRequest);
endmodule : aiw_irq_wake_ctrl
`default_nettype wire

/* aiw_host_model.sv */
/*
 * Host-side model of the board behind the two interrupt pins: resolves
 * each pad into a line level and tells the host when a line signals.
 * Assumes pads given as output level and output enable, high = drives.
 */
`default_nettype none
module aiw_host_model (
    input wire logic polarityHigh, // Polarity the host has programmed.
    input wire logic firstOut, // First pad level.
    input wire logic firstOe, // First pad enable.
    input wire logic secondOut, // Second pad level.
    input wire logic secondOe, // Second pad enable.
    output logic lineFirst, // Resolved first line.
    output logic lineSecond, // Resolved second line.
    output logic irqSeen // Either line shows an event.
);
    logic idleLevel;
    // A released line rests at the inactive level through the board's pull resistor,
    // so open-drain pads from several devices can share one line.
    assign idleLevel = ~polarityHigh;
    assign lineFirst = firstOe ? firstOut : idleLevel;
    assign lineSecond = secondOe ? secondOut : idleLevel;
    // On an event the host goes to read the source register.
    assign irqSeen = (lineFirst != idleLevel) || (lineSecond != idleLevel);
endmodule : aiw_host_model
`default_nettype wire

/* test_accel_interrupt_wake_control.sv */
/*
 * Self-checking bench of the interrupt and wake controller with a host model.
 * Assumes the controller's registered one-cycle latencies for reads and pins.
 */
`default_nettype none
module test_accel_interrupt_wake_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [7:0] src = 8'h00; // Flags in source-register bit order.
    logic [1:0] actOs = 2'h0;
    logic [1:0] slpOs = 2'h0;
    logic sleeping = 1'b0;
    aiw_pkg::aiw_os_scheme_t currentScheme;
    logic wakeRequest, p1o, p1e, p2o, p2e, hostIrq;
    logic chk = 1'b0;
    logic [8:0] expQ[$];
    logic [8:0] expNow;
    logic [7:0] cfgE = 8'h00, enE = 8'h00, rtE = 8'h00, lfsr = 8'h22;
    int n_fail = 0;
    int num_checks = 0;
    // Clock of 100 ns period.
    always #50 clk = ~clk;
    aiw_irq_wake_ctrl aiw_irq_wake_ctrl_inst (.clk(clk), .rst(rst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .srcAutosleep(src[7]), .srcTransient(src[5]), .srcOrientation(src[4]),
        .srcPulse(src[3]), .srcFreefallMotion(src[2]), .srcDataReady(src[0]),
        .activeOversampleScheme(actOs), .sleepOversampleScheme(slpOs), .sleeping(sleeping),
        .currentScheme(currentScheme), .wakeRequest(wakeRequest), .irqPinFirstOut(p1o),
        .irqPinFirstOe(p1e), .irqPinSecondOut(p2o), .irqPinSecondOe(p2e));
    aiw_host_model aiw_host_model_inst (.polarityHigh(cfgE[1]), .firstOut(p1o),
        .firstOe(p1e), .secondOut(p2o), .secondOe(p2e), .lineFirst(),
        .lineSecond(), .irqSeen(hostIrq));
    function automatic logic [7:0] step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : step
    // Expected {first out, first oe, second out, second oe, wake, scheme}.
    function automatic logic [6:0] expOut(input logic [7:0] s);
        logic [7:0] act;
        logic f;
        logic g;
        act = s & enE & aiw_pkg::SRC_MASK;
        f = |(act & rtE);
        g = |(act & ~rtE);
        return {cfgE[1] ? f : ~f, cfgE[0] ? f : 1'b1, cfgE[1] ? g : ~g, cfgE[0] ? g : 1'b1,
            sleeping & |(act & (cfgE >> 1) & aiw_pkg::WAKE_SRC_MASK), sleeping ? slpOs : actOs};
    endfunction : expOut
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        chk = 1'b1;
        expQ.push_back({1'b1, e});
        @(negedge clk);
        regRdEn = 1'b0;
        chk = 1'b0;
    endtask : rd
    // Applies flags and phase inputs, then notes the pin, wake and scheme outcome.
    task automatic look(input logic [7:0] s, input logic [7:0] r);
        @(negedge clk);
        src = s;
        sleeping = r[7];
        actOs = r[1:0];
        slpOs = r[3:2];
        chk = 1'b1;
        // Bit 7 of the note is whether the host should see any line signal.
        expQ.push_back({1'b0, |(s & enE & aiw_pkg::SRC_MASK), expOut(s)});
        @(negedge clk);
        chk = 1'b0;
    endtask : look
    // Monitor: results are checked 10 ns after the edge that took the request.
    always @(posedge clk) begin
        if (chk) begin
            #10;
            expNow = expQ.pop_front();
            if (expNow[8]) begin
                check("read data", regRdData, expNow[7:0]);
            end else begin
                check("pins",
                    {1'b0, p1o, p1e, p2o, p2e, wakeRequest, currentScheme},
                    {1'b0, expNow[6:0]});
                check("host line", {7'h00, hostIrq}, {7'h00, expNow[7]});
            end
        end
    end
    // Watchdog well beyond the roughly 990 cycles the sequence needs.
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    // Reset, default values, then randomised configurations and flags.
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        look(8'hBD, 8'h80);
        rd(aiw_pkg::ADDR_WAKE_CFG, 8'h00);
        rd(aiw_pkg::ADDR_INT_ENABLE, 8'h00);
        rd(aiw_pkg::ADDR_INT_ROUTE, 8'h00);
        for (int i = 0; i < 60; i++) begin
            lfsr = step(lfsr);
            wr(aiw_pkg::ADDR_WAKE_CFG, lfsr);
            cfgE = lfsr & aiw_pkg::WAKE_CFG_MASK;
            lfsr = step(step(lfsr));
            wr(aiw_pkg::ADDR_INT_ENABLE, lfsr);
            enE = lfsr & aiw_pkg::SRC_MASK;
            lfsr = step(step(step(lfsr)));
            wr(aiw_pkg::ADDR_INT_ROUTE, lfsr);
            rtE = lfsr & aiw_pkg::SRC_MASK;
            rd(aiw_pkg::ADDR_WAKE_CFG, cfgE);
            rd(aiw_pkg::ADDR_INT_ENABLE, enE);
            rd(aiw_pkg::ADDR_INT_ROUTE, rtE);
            lfsr = step(lfsr);
            look(lfsr, step(lfsr));
            // The host reads the sources only when a line signals.
            if (hostIrq) begin
                rd(aiw_pkg::ADDR_INT_SOURCE, src & aiw_pkg::SRC_MASK);
            end else begin
                rd(8'h2F, 8'h00);
            end
        end
        // A second reset in mid-run must bring every register back to zero.
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        cfgE = 8'h00;
        enE = 8'h00;
        rtE = 8'h00;
        rd(aiw_pkg::ADDR_WAKE_CFG, 8'h00);
        rd(aiw_pkg::ADDR_INT_ENABLE, 8'h00);
        rd(aiw_pkg::ADDR_INT_ROUTE, 8'h00);
        look(8'hBD, 8'h80);
        complete_run();
    end
endmodule : test_accel_interrupt_wake_control
`default_nettype wire
